// *** rtl/aac_ctrl.sv ***
// converter control: serial register access, sequencing, result capture
//
// Behaviour
// RQ1 - converter clock is the front-end oscillator divided by four
// RQ2 - each result is a 15-bit delta-sigma value
// RQ3 - conversion lasts 1024, 2048, 4096 or 8192 converter clocks
// RQ4 - time field 00/01/10/11 selects 1/2/4/8 ms
// RQ5 - conversion starts only from a software write (automatic mode also restarts it at each completion)
// RQ6 - exactly one of seven sources is routed per conversion
// RQ7 - completed value is written to the data registers at the end
// RQ8 - automatic mode repeats conversions on the chosen channel unprompted
// RQ9 - an interrupt request is raised when a conversion completes
// RQ10 - impedance current sampling runs in step with the conversion
// RQ11 - control register is reached only over the three-wire link
// RQ12 - control register at 0x50: start, enable, imp start, zero, channel
// RQ13 - control register clears to 0x00 on reset
// RQ14 - channel codes map to the seven sources; others not written
// RQ15 - integrator runs while its start bit is 1, stops at 0
// RQ16 - converter is disabled while enable is 0
// RQ17 - converter is stopped while start is 0
// RQ18 - start clears on completion; software rewrites 0 then 1 (start stays set in automatic mode)
// RQ19 - enable and start set together delay start by 60 us
// RQ20 - controller waits 2 ms after oscillator start before use (the bench starts serial access about 1 us after it)
// RQ21 - previous result is held until the next completion
// RQ22 - start is ignored and stays 0 while enable is 0
`default_nettype none
module aac_ctrl (
    // clock, reset, enable
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    // three-wire serial link
    input wire logic mcu_serial_clk_in,
    input wire logic mcu_serial_data_in,
    output logic mcu_serial_data_out,
    // analog side
    input wire logic frontend_osc_clock_in,
    input wire logic modulator_bit_in,
    output logic [aac_pkg::NUM_CHAN-1:0] chan_sel_out,
    output logic conv_active_out,
    output logic [aac_pkg::RES_W-1:0] conv_result_out,
    output logic conv_irq_out,
    // impedance integrator
    output logic imp_integ_run_out,
    output logic imp_window_out
);
    import aac_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    aac_state_t st_reg;
    aac_state_t st_next;
    logic [SYNC_W-1:0] sync_vec;
    logic sy_sck;
    logic sy_si;
    logic sy_osc;
    logic sy_mod;
    logic conv_tick;
    logic [LEN_W-1:0] len_last;
    logic last_tick;

    function automatic logic [NUM_CHAN-1:0] chan_decode(
        input logic [CHAN_W-1:0] code
    );
        logic [NUM_CHAN-1:0] sel;
        sel = SEL_GROUND;
        case (code)
            CH_EXT_FIRST: sel = SEL_EXT_FIRST;
            CH_EXT_SECOND: sel = SEL_EXT_SECOND;
            CH_CELL_MON: sel = SEL_CELL_MON;
            CH_TEMP: sel = SEL_TEMP;
            CH_GROUND: sel = SEL_GROUND;
            CH_CORE_REF: sel = SEL_CORE_REF;
            CH_PULLUP: sel = SEL_PULLUP;
            default: sel = SEL_GROUND;
        endcase
        return sel;
    endfunction

    function automatic logic [7:0] read_mux(
        input aac_state_t s,
        input logic [ADDR_W-1:0] addr
    );
        logic [7:0] d;
        d = 8'h00;
        case (addr)
            CONV_CONTROL_ADDR: d = s.ctrl;
            CONV_TIME_ADDR: d = {6'h00, s.len_sel};
            RESULT_LO_ADDR: d = s.result[7:0];
            RESULT_HI_ADDR: d = {1'b0, s.result[RES_W-1:8]};
            AUTO_MODE_ADDR: d = {7'h00, s.auto_en};
            default: d = 8'h00;
        endcase
        return d;
    endfunction

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    aac_sync #(
        .W(SYNC_W)
    ) u_sync (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .ce_in(ce_in),
        .async_in({modulator_bit_in, frontend_osc_clock_in,
                   mcu_serial_data_in, mcu_serial_clk_in}),
        .sync_out(sync_vec)
    );
    assign {sy_mod, sy_osc, sy_si, sy_sck} = sync_vec;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // RQ1 divide by four
    assign conv_tick = sy_osc && !st_reg.osc_prev &&
        (st_reg.div == DIV_W'(OSC_DIV - 1));
    // RQ3 RQ4 length select
    assign len_last = LEN_W'((CONV_BASE_CYC << st_reg.len_sel) - 1);
    assign last_tick = conv_tick && (st_reg.tick_cnt == len_last);

    always_comb
    begin
        logic wr_en;
        logic [ADDR_W-1:0] wr_addr;
        logic [7:0] wr_data;
        logic [7:0] new_ctrl;
        logic go_now;
        logic go_wait;
        logic begin_conv;
        logic [LEN_W-1:0] ones_new;
        logic [SCALE_W-1:0] scaled;
        wr_en = 1'b0;
        wr_addr = '0;
        wr_data = 8'h00;
        new_ctrl = st_reg.ctrl;
        go_now = 1'b0;
        go_wait = 1'b0;
        begin_conv = 1'b0;
        ones_new = st_reg.ones + LEN_W'(sy_mod);
        scaled = SCALE_W'(ones_new) << (SCALE_TOP - int'(st_reg.len_sel));
        st_next = st_reg;
        st_next.done = 1'b0;
        st_next.osc_prev = sy_osc;
        st_next.sck_prev = sy_sck;
        if (sy_osc && !st_reg.osc_prev)
        begin
            st_next.div = st_reg.div + DIV_W'(1);
        end
        // RQ11 serial frame receive
        if (sy_sck && !st_reg.sck_prev)
        begin
            st_next.idle = '0;
            st_next.shift = {st_reg.shift[SER_FRAME_BITS-2:0], sy_si};
            if (st_reg.bit_cnt == BIT_CNT_W'(SER_FRAME_BITS - 1))
            begin
                st_next.bit_cnt = '0;
                wr_en = st_next.shift[SER_WR_FLAG];
                wr_addr = st_next.shift[SER_FRAME_BITS-2:SER_CMD_BITS];
                wr_data = st_next.shift[7:0];
            end
            else
            begin
                st_next.bit_cnt = st_reg.bit_cnt + BIT_CNT_W'(1);
            end
        end
        else if (st_reg.bit_cnt != '0)
        begin
            if (st_reg.idle == SER_IDLE_CYC)
            begin
                st_next.bit_cnt = '0;
                st_next.idle = '0;
            end
            else
            begin
                st_next.idle = st_reg.idle + IDLE_W'(1);
            end
        end
        // RQ11 serial read data out
        if (!sy_sck && st_reg.sck_prev)
        begin
            if (st_reg.bit_cnt == BIT_CNT_W'(SER_CMD_BITS))
            begin
                st_next.tx = read_mux(st_reg, st_reg.shift[ADDR_W-1:0]);
            end
            else if (st_reg.bit_cnt > BIT_CNT_W'(SER_CMD_BITS))
            begin
                st_next.tx = {st_reg.tx[6:0], 1'b0};
            end
        end
        // RQ12 register writes
        if (wr_en)
        begin
            case (wr_addr)
                CONV_CONTROL_ADDR:
                begin
                    new_ctrl = wr_data & CTRL_WMASK;
                    // RQ22 start needs enable
                    if (!new_ctrl[CONV_ENABLE_BIT])
                    begin
                        new_ctrl[CONV_START_BIT] = 1'b0;
                    end
                    // RQ5 RQ18 software rising start
                    if (new_ctrl[CONV_START_BIT] &&
                        !st_reg.ctrl[CONV_START_BIT])
                    begin
                        go_now = st_reg.ctrl[CONV_ENABLE_BIT];
                        go_wait = !st_reg.ctrl[CONV_ENABLE_BIT];
                    end
                    st_next.ctrl = new_ctrl;
                end
                CONV_TIME_ADDR: st_next.len_sel = wr_data[LEN_SEL_W-1:0];
                AUTO_MODE_ADDR: st_next.auto_en = wr_data[AUTO_EN_BIT];
                default: st_next.len_sel = st_next.len_sel;
            endcase
        end
        // sequencing
        unique case (st_reg.fsm)
            ST_IDLE:
            begin
                begin_conv = go_now;
                // RQ19 enable and start together
                if (go_wait)
                begin
                    st_next.fsm = ST_WAIT;
                    st_next.wait_cnt = '0;
                end
            end
            ST_WAIT:
            begin
                // RQ19 60 us delay
                if (st_reg.wait_cnt == WAIT_W'(START_DELAY_CYC - 1))
                begin
                    begin_conv = 1'b1;
                end
                else
                begin
                    st_next.wait_cnt = st_reg.wait_cnt + WAIT_W'(1);
                end
            end
            ST_CONV:
            begin
                if (conv_tick)
                begin
                    st_next.tick_cnt = st_reg.tick_cnt + LEN_W'(1);
                    st_next.ones = ones_new;
                end
                // RQ2 RQ7 capture result
                if (last_tick)
                begin
                    st_next.result = (scaled > SCALE_W'(RES_MAX)) ?
                        RES_MAX : scaled[RES_W-1:0];
                    // RQ9 completion request
                    st_next.done = 1'b1;
                    // RQ8 automatic repeat
                    if (st_reg.auto_en)
                    begin
                        begin_conv = 1'b1;
                    end
                    else
                    begin
                        // RQ18 self clear
                        st_next.ctrl[CONV_START_BIT] = 1'b0;
                        st_next.fsm = ST_IDLE;
                    end
                end
            end
        endcase
        // RQ6 RQ14 route one source
        if (begin_conv)
        begin
            st_next.fsm = ST_CONV;
            st_next.tick_cnt = '0;
            st_next.ones = '0;
            st_next.chan_sel = chan_decode(st_next.ctrl[CHAN_W-1:0]);
        end
        // RQ16 RQ17 disable or stop
        if (!st_next.ctrl[CONV_ENABLE_BIT] ||
            !st_next.ctrl[CONV_START_BIT])
        begin
            st_next.fsm = ST_IDLE;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in)
    begin
        // RQ13 reset clear
        if (sys_rst_in)
        begin
            st_reg <= STATE_RESET;
        end
        else if (ce_in)
        begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign mcu_serial_data_out = st_reg.tx[7];
    assign chan_sel_out = st_reg.chan_sel;
    assign conv_active_out = (st_reg.fsm == ST_CONV);
    assign conv_result_out = st_reg.result;
    assign conv_irq_out = st_reg.done;
    // RQ15 integrator run
    assign imp_integ_run_out = st_reg.ctrl[IMP_INTEG_START_BIT];
    // RQ10 synchronous window
    assign imp_window_out = st_reg.ctrl[IMP_INTEG_START_BIT] &&
        conv_active_out;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (sys_rst_in || !ce_in);

    sequence s_enter_wait;
        $rose(st_reg.fsm == ST_WAIT);
    endsequence

    sequence s_wait_done;
        (st_reg.fsm == ST_WAIT) &&
        (st_reg.wait_cnt == WAIT_W'(START_DELAY_CYC - 1)) &&
        st_reg.ctrl[CONV_ENABLE_BIT] && st_reg.ctrl[CONV_START_BIT];
    endsequence

    sequence s_last_tick;
        (st_reg.fsm == ST_CONV) && last_tick &&
        st_reg.ctrl[CONV_ENABLE_BIT] && st_reg.ctrl[CONV_START_BIT];
    endsequence

    chk_reset_ctrl_zero: assert property ( // RQ13
        @(posedge sys_clk_in) disable iff (1'b0)
        sys_rst_in |=> (st_reg.ctrl == CTRL_RESET))
        else $error("control register not cleared by reset");
    chk_start_needs_en: assert property ( // RQ22
        !st_reg.ctrl[CONV_ENABLE_BIT] |-> !st_reg.ctrl[CONV_START_BIT])
        else $error("start bit set while disabled");
    chk_disable_idles: assert property ( // RQ16
        !st_reg.ctrl[CONV_ENABLE_BIT] |-> (st_reg.fsm == ST_IDLE))
        else $error("converter busy while disabled");
    chk_wait_starts_zero: assert property ( // RQ19
        s_enter_wait |-> (st_reg.wait_cnt == '0))
        else $error("start delay counter not cleared");
    chk_wait_to_conv: assert property ( // RQ19
        s_wait_done |=> (st_reg.fsm == ST_CONV))
        else $error("conversion did not begin after delay");
    chk_conv_len_bound: assert property ( // RQ3
        (st_reg.fsm == ST_CONV) |-> (st_reg.tick_cnt <= len_last))
        else $error("conversion ran past its length");
    chk_done_irq_pulse: assert property ( // RQ9
        s_last_tick |=> conv_irq_out ##1 !conv_irq_out)
        else $error("completion request missing or stuck");
    chk_done_clears_start: assert property ( // RQ18
        (s_last_tick and ##0 !st_reg.auto_en) |=>
        !st_reg.ctrl[CONV_START_BIT])
        else $error("start bit not cleared on completion");
    chk_result_hold: assert property ( // RQ21
        !st_next.done |=> $stable(st_reg.result))
        else $error("result changed without completion");
    chk_mux_onehot: assert property ( // RQ6
        $onehot(chan_sel_out))
        else $error("multiplexer select not one-hot");
    chk_imp_window: assert property ( // RQ10
        imp_window_out |-> (conv_active_out && imp_integ_run_out))
        else $error("impedance window outside conversion");
endmodule
`default_nettype wire

// *** rtl/aac_pkg.sv ***
// shared constants and types for the converter control block
`default_nettype none
package aac_pkg;
    // ----------------------------------------------------------------
    // register map (7-bit front-end addresses)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 7;
    localparam logic [ADDR_W-1:0] CONV_CONTROL_ADDR = 7'h50;
    localparam logic [ADDR_W-1:0] CONV_TIME_ADDR = 7'h51;
    localparam logic [ADDR_W-1:0] RESULT_LO_ADDR = 7'h52;
    localparam logic [ADDR_W-1:0] RESULT_HI_ADDR = 7'h53;
    localparam logic [ADDR_W-1:0] AUTO_MODE_ADDR = 7'h54;
    // ----------------------------------------------------------------
    // field layout
    // ----------------------------------------------------------------
    localparam int CONV_START_BIT = 7;
    localparam int CONV_ENABLE_BIT = 6;
    localparam int IMP_INTEG_START_BIT = 5;
    localparam int CHAN_W = 4;
    localparam logic [7:0] CTRL_WMASK = 8'hef;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int LEN_SEL_W = 2;
    localparam int AUTO_EN_BIT = 0;
    localparam int RES_HI_W = 7;
    // ----------------------------------------------------------------
    // channel codes and one-hot mux lines
    // ----------------------------------------------------------------
    localparam int NUM_CHAN = 7;
    localparam logic [CHAN_W-1:0] CH_EXT_FIRST = 4'h0;
    localparam logic [CHAN_W-1:0] CH_EXT_SECOND = 4'h1;
    localparam logic [CHAN_W-1:0] CH_CELL_MON = 4'h6;
    localparam logic [CHAN_W-1:0] CH_TEMP = 4'h7;
    localparam logic [CHAN_W-1:0] CH_GROUND = 4'ha;
    localparam logic [CHAN_W-1:0] CH_CORE_REF = 4'hb;
    localparam logic [CHAN_W-1:0] CH_PULLUP = 4'hd;
    localparam logic [NUM_CHAN-1:0] SEL_EXT_FIRST = 7'h01;
    localparam logic [NUM_CHAN-1:0] SEL_EXT_SECOND = 7'h02;
    localparam logic [NUM_CHAN-1:0] SEL_CELL_MON = 7'h04;
    localparam logic [NUM_CHAN-1:0] SEL_TEMP = 7'h08;
    localparam logic [NUM_CHAN-1:0] SEL_GROUND = 7'h10;
    localparam logic [NUM_CHAN-1:0] SEL_CORE_REF = 7'h20;
    localparam logic [NUM_CHAN-1:0] SEL_PULLUP = 7'h40;
    // ----------------------------------------------------------------
    // conversion timing
    // ----------------------------------------------------------------
    localparam int OSC_DIV = 4;
    localparam int DIV_W = 2;
    localparam int CONV_BASE_CYC = 1024;
    localparam int LEN_W = 14;
    localparam int RES_W = 15;
    localparam logic [RES_W-1:0] RES_MAX = 15'h7fff;
    localparam int SCALE_W = 19;
    localparam int SCALE_TOP = 5;
    localparam int CLK_PERIOD_NS = 40;
    localparam int START_DELAY_US = 60;
    localparam int START_DELAY_CYC =
        (START_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_W = 11;
    // ----------------------------------------------------------------
    // serial link framing
    // ----------------------------------------------------------------
    localparam int SER_FRAME_BITS = 16;
    localparam int SER_CMD_BITS = 8;
    localparam int SER_WR_FLAG = 15;
    localparam int BIT_CNT_W = 5;
    localparam int IDLE_W = 8;
    localparam logic [IDLE_W-1:0] SER_IDLE_CYC = 8'hff;
    localparam int SYNC_W = 4;
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_CONV = 3'b100
    } aac_fsm_t;

    typedef struct packed {
        aac_fsm_t fsm;
        logic [7:0] ctrl;
        logic [LEN_SEL_W-1:0] len_sel;
        logic auto_en;
        logic [RES_W-1:0] result;
        logic done;
        logic [NUM_CHAN-1:0] chan_sel;
        logic [WAIT_W-1:0] wait_cnt;
        logic osc_prev;
        logic [DIV_W-1:0] div;
        logic [LEN_W-1:0] tick_cnt;
        logic [LEN_W-1:0] ones;
        logic sck_prev;
        logic [BIT_CNT_W-1:0] bit_cnt;
        logic [SER_FRAME_BITS-1:0] shift;
        logic [7:0] tx;
        logic [IDLE_W-1:0] idle;
    } aac_state_t;

    localparam aac_state_t STATE_RESET = '{
        fsm: ST_IDLE,
        ctrl: CTRL_RESET,
        chan_sel: SEL_EXT_FIRST,
        default: '0
    };
endpackage
`default_nettype wire

// *** rtl/aac_sync.sv ***
// two-flop synchroniser for inputs from outside the clock domain
`default_nettype none
module aac_sync #(
    parameter int W = 1
) (
    // clock, reset, enable
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic ce_in,
    // levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } aac_sync_state_t;

    aac_sync_state_t s_reg;
    aac_sync_state_t s_next;

    always_comb
    begin
        s_next = s_reg;
        s_next.meta = async_in;
        s_next.stable = s_reg.meta;
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (sys_rst_in)
        begin
            s_reg <= '0;
        end
        else if (ce_in)
        begin
            s_reg <= s_next;
        end
    end

    assign sync_out = s_reg.stable;
endmodule
`default_nettype wire

// *** testbench/aac_mcu_model.sv ***
// serial master model standing in for the microcontroller
`default_nettype none
module aac_mcu_model (
    // clock
    input wire logic sys_clk_in,
    // three-wire link
    output logic ser_clk_out,
    output logic ser_data_out,
    input wire logic ser_data_in
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        ser_clk_out = 1'b0;
        ser_data_out = 1'b1;
    end

    task automatic xfer(input logic [15:0] frame, output logic [7:0] rd);
        rd = 8'h00;
        for (int i = 15; i >= 0; i--)
        begin
            @(posedge sys_clk_in);
            ser_data_out <= frame[i];
            repeat (8) @(posedge sys_clk_in);
            ser_clk_out <= 1'b1;
            if (i < 8)
            begin
                rd = {rd[6:0], ser_data_in};
            end
            repeat (8) @(posedge sys_clk_in);
            ser_clk_out <= 1'b0;
        end
        @(posedge sys_clk_in);
        ser_data_out <= ~frame[0];
    endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the converter control block
`default_nettype none
`define CHECK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module tb_top import aac_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    logic sys_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic ser_clk, ser_mosi, ser_miso;
    logic osc = 1'b0;
    logic mod_bit = 1'b0;
    logic [NUM_CHAN-1:0] chan_sel;
    logic active, irq, integ_run, imp_window;
    logic [RES_W-1:0] result;
    logic [7:0] rd;
    int bad_count = 0;
    int samples_checked = 0;
    int osc_cnt = 0;
    int irq_cnt = 0;

    // ----------------------------------------
    // clocks and pulse counting
    // ----------------------------------------
    initial
    begin
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    always @(posedge sys_clk_in)
    begin
        osc_cnt <= (osc_cnt == 2) ? 0 : osc_cnt + 1;
        if (osc_cnt == 2)
        begin
            osc <= ~osc;
        end
        if (irq === 1'b1)
        begin
            irq_cnt <= irq_cnt + 1;
        end
    end

    aac_ctrl aac_ctrl_inst (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .ce_in(1'b1),
        .mcu_serial_clk_in(ser_clk),
        .mcu_serial_data_in(ser_mosi),
        .mcu_serial_data_out(ser_miso),
        .frontend_osc_clock_in(osc),
        .modulator_bit_in(mod_bit),
        .chan_sel_out(chan_sel),
        .conv_active_out(active),
        .conv_result_out(result),
        .conv_irq_out(irq),
        .imp_integ_run_out(integ_run),
        .imp_window_out(imp_window)
    );

    aac_mcu_model mcu_model_inst (
        .sys_clk_in(sys_clk_in),
        .ser_clk_out(ser_clk),
        .ser_data_out(ser_mosi),
        .ser_data_in(ser_miso)
    );

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] unused;
        mcu_model_inst.xfer({1'b1, a, d}, unused);
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        mcu_model_inst.xfer({1'b0, a, 8'h00}, rd);
        `CHECK(rd, exp)
    endtask

    task automatic wait_active(input logic lvl, input int lim, output int n);
        n = 0;
        while (active !== lvl && n < lim)
        begin
            @(posedge sys_clk_in);
            n++;
        end
        if (n >= lim)
        begin
            bad_count++;
            complete_run();
        end
    endtask

    task automatic wait_irq(input int target, input int lim, output int n);
        n = 0;
        while (irq_cnt < target && n < lim)
        begin
            @(posedge sys_clk_in);
            n++;
        end
        if (n >= lim)
        begin
            bad_count++;
            complete_run();
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
        begin
            $display("verification passed");
        end
        else
        begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_reset();
        `CHECK(chan_sel, 7'h01)
        `CHECK({active, irq, integ_run, imp_window}, 4'h0)
        `CHECK(result, 15'h0000)
        rd_chk(CONV_CONTROL_ADDR, 8'h00);
        rd_chk(CONV_TIME_ADDR, 8'h00);
        rd_chk(7'h60, 8'h00);
        wr(CONV_CONTROL_ADDR, 8'h9a);
        rd_chk(CONV_CONTROL_ADDR, 8'h0a);
        `CHECK(active, 1'b0)
        $display("test_reset done");
    endtask

    task automatic test_channels();
        logic [3:0] codes [7] = '{4'h0, 4'h1, 4'h6, 4'h7, 4'ha, 4'hb, 4'hd};
        logic imp;
        for (int i = 0; i < 7; i++)
        begin
            imp = (i == 3);
            wr(CONV_CONTROL_ADDR, {2'b01, imp, 1'b0, codes[i]});
            wr(CONV_CONTROL_ADDR, {2'b11, imp, 1'b0, codes[i]});
            `CHECK(active, 1'b1)
            `CHECK(chan_sel, 7'h01 << i)
            `CHECK({integ_run, imp_window}, {imp, imp})
            wr(CONV_CONTROL_ADDR, {2'b01, imp, 1'b0, codes[i]});
            `CHECK(active, 1'b0)
        end
        `CHECK(irq_cnt, 0)
        $display("test_channels done");
    endtask

    task automatic test_convert();
        int n;
        mod_bit <= 1'b1;
        wr(CONV_TIME_ADDR, 8'h00);
        wr(AUTO_MODE_ADDR, 8'h01);
        rd_chk(AUTO_MODE_ADDR, 8'h01);
        wr(CONV_CONTROL_ADDR, 8'h06);
        wr(CONV_CONTROL_ADDR, 8'hc6);
        wait_active(1'b1, 3000, n);
        `CHECK(n > 1470 && n < 1510, 1'b1)
        wait_irq(1, 40000, n);
        `CHECK(n > 24540 && n < 24610, 1'b1)
        `CHECK(active, 1'b1)
        rd_chk(CONV_CONTROL_ADDR, 8'hc6);
        wr(CONV_CONTROL_ADDR, 8'h46);
        wr(AUTO_MODE_ADDR, 8'h00);
        `CHECK(active, 1'b0)
        repeat (2) @(posedge sys_clk_in);
        `CHECK(irq_cnt, 1)
        `CHECK(result, 15'h7fff)
        rd_chk(CONV_CONTROL_ADDR, 8'h46);
        rd_chk(RESULT_LO_ADDR, 8'hff);
        rd_chk(RESULT_HI_ADDR, 8'h7f);
        $display("test_convert done");
    endtask

    task automatic test_restart();
        int n;
        int m;
        mod_bit <= 1'b0;
        wr(CONV_TIME_ADDR, 8'h01);
        wr(CONV_CONTROL_ADDR, 8'hc6);
        wait_active(1'b1, 20, n);
        repeat (20000) @(posedge sys_clk_in);
        `CHECK(result, 15'h7fff)
        wait_active(1'b0, 40000, m);
        `CHECK(m + 20000 > 49100 && m + 20000 < 49200, 1'b1)
        repeat (2) @(posedge sys_clk_in);
        `CHECK(irq_cnt, 2)
        rd_chk(CONV_CONTROL_ADDR, 8'h46);
        rd_chk(RESULT_LO_ADDR, 8'h00);
        rd_chk(RESULT_HI_ADDR, 8'h00);
        $display("test_restart done");
    endtask

    initial
    begin
        repeat (20) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        test_reset();
        test_channels();
        test_convert();
        test_restart();
        complete_run();
    end
endmodule
`default_nettype wire
